// *** eepec_array_model.sv ***
// Array-side model: program/erase timing and read data of the cells.
`timescale 1ns/100ps
module eepec_array_model #(
  parameter int DONE_DLY = 20
) (
  // Clock.
  input  wire logic        clk_in,
  // Array link.
  input  wire logic        hv_in,
  input  wire logic [11:0] raddr_in,
  output logic      [7:0]  rdata_out,
  output logic             done_out
);
  int cnt;

  // Cells read as the inverted low index byte, so locations 256 apart read the same.
  assign rdata_out = ~raddr_in[7:0];

  // Start idle, so that no cycle appears to complete before the first one.
  initial begin
    cnt = 0;
    done_out = 1'b0;
  end

  // Done pulses once after the voltage has stood DONE_DLY cycles; the count
  // runs on past that, so a long voltage phase never sees a second pulse.
  always @(posedge clk_in) begin
    cnt <= hv_in ? cnt + 1 : 0;
    done_out <= hv_in && (cnt == DONE_DLY);
  end
endmodule // eepec_array_model

// *** eepec_bench.sv ***
// Self-checking bench of the program/erase control over Wishbone.
`timescale 1ns/100ps
module eepec_bench;
  logic        clk_in, arst_n_in, cyc, stb, we, done, hv;
  logic [15:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rd;
  logic        ack, latch, erase, byt, row, word;
  logic [7:0]  rdata;
  logic [11:0] raddr, taddr;
  logic [15:0] tdata;
  logic [9:0]  div;
  logic [3:0]  wsel;
  logic        smn;
  int          err_total, check_count, n;
  logic [7:0]  cfg [6] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h18, 8'h1e};
  logic [7:0]  grd [2] = '{8'h20, 8'h00};
  logic [7:0]  mode [2] = '{8'h22, 8'hae};

  eepec_top i_eepec_top (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .special_mode_n_in(smn), .shadow_word_in(16'hbe5a),
    .nv_rdata_in(rdata), .nv_done_in(done), .nv_raddr_out(raddr),
    .nv_addr_out(taddr), .nv_data_out(tdata), .nv_word_out(word),
    .nv_latch_out(latch), .nv_erase_out(erase), .nv_byte_out(byt),
    .nv_row_out(row), .nv_hv_out(hv), .nv_div_out(div));

  eepec_array_model #(.DONE_DLY(20)) i_eepec_array_model (.clk_in(clk_in),
    .hv_in(hv), .raddr_in(raddr), .rdata_out(rdata), .done_out(done));

  // Clock at 100 MHz.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // One classic cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [15:0] a, input logic [15:0] d);
    int k;
    @(posedge clk_in);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, 16'h0, d, wsel};
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) err_total++;
    rd = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard: the sequence needs well under 5000 cycles.
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    summarize();
  end

  // Main sequence.
  initial begin
    err_total = 0;
    check_count = 0;
    {arst_n_in, cyc, stb, we, adr, sel, wdat} = '0;
    smn = 1'b1;
    wsel = 4'h1;
    repeat (16) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rdchk(16'h0000, 8'h80);
    rdchk(16'h0010, 8'hff);
    rdchk(16'h0020, 8'h00);
    rdchk(16'h0004, 8'hb0);
    rdchk(16'h0008, 8'h02);
    rdchk(16'h000c, 8'h5a);
    rdchk(16'hbf00, 8'hbe);
    rdchk(16'hbf04, 8'h5a);
    wb(1'b1, 16'h0004, 8'h40);
    rdchk(16'hbf00, 8'h3f);
    // Only the first write to each divider byte after reset may land.
    wb(1'b1, 16'h0008, 8'h01);
    wb(1'b1, 16'h000c, 8'h33);
    wb(1'b1, 16'h0008, 8'h03);
    wb(1'b1, 16'h000c, 8'h44);
    rdchk(16'h0008, 8'h01);
    rdchk(16'h000c, 8'h33);
    chk(div, 10'h133);
    // Mode bits change one or several per write, in no fixed order.
    foreach (cfg[i]) begin
      wb(1'b1, 16'h0000, cfg[i]);
      chk({byt, row, erase, latch}, cfg[i][4:1]);
    end
    wb(1'b1, 16'h0000, 8'h00);
    wb(1'b1, 16'h0000, 8'h03);
    rdchk(16'h0000, 8'h02);
    // Word target at an even index, then a byte target at an odd one.
    wsel = 4'h3;
    wb(1'b1, 16'ha018, 16'h1234);
    chk({word, taddr, tdata}, 29'h1806_1234);
    // Auto-cleared byte program into an unguarded block.
    wb(1'b1, 16'h0010, 8'h00);
    wb(1'b1, 16'h0000, 8'h22);
    wb(1'b1, 16'ha014, 16'h77a5);
    wsel = 4'h1;
    chk({word, tdata}, 17'h000a5);
    chk({taddr, tdata[7:0]}, 20'h805a5);
    wb(1'b1, 16'h0000, 8'h23);
    @(posedge clk_in);
    chk(hv, 1'b1);
    wb(1'b1, 16'ha014, 8'h5a);
    wb(1'b1, 16'h0000, 8'h27);
    chk({taddr, tdata[7:0]}, 20'h805a5);
    chk(erase, 1'b0);
    n = 0;
    do begin
      wb(1'b0, 16'h0000, 8'h00);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    chk(rd, 32'h22);
    chk(hv, 1'b0);
    wb(1'b1, 16'h0000, 8'h00);
    // A guarded block, then a row erase under the bulk guard, never start.
    foreach (grd[i]) begin
      wb(1'b1, 16'h0010, grd[i]);
      wb(1'b1, 16'h0000, mode[i]);
      wb(1'b1, 16'ha014, 8'h0f);
      wb(1'b1, 16'h0000, mode[i] | 8'h01);
      repeat (30) @(posedge clk_in);
      rdchk(16'h0000, mode[i] | 8'h01);
      chk(hv, 1'b0);
      wb(1'b1, 16'h0000, mode[i]);
      wb(1'b1, 16'h0000, 8'h00);
    end
    // Manual cycle: enable stays after done until software clears it.
    wb(1'b1, 16'h0000, 8'h02);
    wb(1'b1, 16'ha014, 8'h11);
    wb(1'b1, 16'h0000, 8'h03);
    repeat (30) @(posedge clk_in);
    rdchk(16'h0000, 8'h03);
    rdchk(16'h0014, 8'he4);
    chk(hv, 1'b0);
    wb(1'b1, 16'h0000, 8'h02);
    wb(1'b1, 16'ha018, 8'h22);
    chk({taddr, tdata[7:0]}, 20'h80622);
    wb(1'b1, 16'h0000, 8'h00);
    rdchk(16'h0014, 8'h61);
    // Special mode leaves the divider writable for a shadow preload.
    smn <= 1'b0;
    wb(1'b1, 16'h000c, 8'h66);
    rdchk(16'h000c, 8'h66);
    smn <= 1'b1;
    summarize();
  end
endmodule // eepec_bench

// *** eepec_params.svh ***
// Offsets, field positions, reset values and limits of the EEPROM control.
`ifndef EEPEC_PARAMS_SVH
`define EEPEC_PARAMS_SVH
// Register byte offsets on the bus; bit 15 set selects the array window.
`define EEPEC_OFS_PEC    16'h0000
`define EEPEC_OFS_CFG    16'h0004
`define EEPEC_OFS_DIVH   16'h0008
`define EEPEC_OFS_DIVL   16'h000c
`define EEPEC_OFS_PROT   16'h0010
`define EEPEC_OFS_STAT   16'h0014
`define EEPEC_ARR_BIT    15
// Array index width; one array byte per bus word.
`define EEPEC_AW         12
// Program/erase control fields.
`define EEPEC_WHOLE_ARRAY_ERASE_GUARD      7
`define EEPEC_AUTO       5
`define EEPEC_BYTE       4
`define EEPEC_ROW        3
`define EEPEC_ERASE      2
`define EEPEC_LATCH      1
`define EEPEC_PGM        0
// Module configuration fields.
`define EEPEC_SHW        6
// Block guard fields; bit 7 guards the shadow word.
`define EEPEC_SHADOW_PROTECT     7
// Reset values.
`define EEPEC_PEC_RST    8'h80
`define EEPEC_PROT_RST   8'hff
// Shadow word location and block ranges, block 0 in the lowest slot.
`define EEPEC_SHADOW_LOC 12'hfc0
`define EEPEC_BLK_LO {12'h800,12'hc00,12'he00,12'hf00,12'hf80,12'hfc0}
`define EEPEC_BLK_HI {12'hbff,12'hdff,12'heff,12'hf7f,12'hfbf,12'hfff}
`endif

// *** eepec_pkg.sv ***
// Types shared by the EEPROM program/erase control.
package eepec_pkg;
  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    eepec_idle = 4'h1,
    eepec_run  = 4'h2,
    eepec_done = 4'h4,
    eepec_held = 4'h8
  } eepec_state_type;
endpackage

// *** eepec_top.sv ***
// EEPROM program/erase control with a classic Wishbone register slave.
//
// What this block does
// - Latch bit 0 serves normal reads; 1 captures a target location.
// - Erase bit 0 sets up programming, 1 sets up erasure.
// - Erase by byte, aligned word, row or whole array unless guarded.
// - Latch writes ignored while program enable set or divider zero.
// - Granularity, erase and latch bits take one write or several.
// - Program enable sets only if latch already set.
// - While program enable set, other control bits stay fixed.
// - Program voltage only while program enable is one.
// - With auto, hardware clears program enable when the cycle ends.
// - Protected target: no cycle starts and enable stays set.
// - While enabled, array writes ignored and latches hold.
// - Shadow word visible at top of block only while hide bit zero.
// - After reset, shadow word loads configuration and divider bits.
// - In normal mode each divider byte accepts only its first write.
// - Bulk guard set refuses bulk and row erase.
// - Each block guard bit set protects its block.
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`include "eepec_params.svh"

module eepec_top (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [15:0] wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Device mode and shadow word.
  input  wire logic        special_mode_n_in,
  input  wire logic [15:0] shadow_word_in,
  // Array side.
  input  wire logic [7:0]  nv_rdata_in,
  input  wire logic        nv_done_in,
  output logic      [11:0] nv_raddr_out,
  output logic      [11:0] nv_addr_out,
  output logic      [15:0] nv_data_out,
  output logic             nv_word_out,
  output logic             nv_latch_out,
  output logic             nv_erase_out,
  output logic             nv_byte_out,
  output logic             nv_row_out,
  output logic             nv_hv_out,
  output logic      [9:0]  nv_div_out
);

  localparam logic [5:0][11:0] BLK_LO = `EEPEC_BLK_LO;
  localparam logic [5:0][11:0] BLK_HI = `EEPEC_BLK_HI;
  localparam logic [11:0]      SHADOW_LOC = `EEPEC_SHADOW_LOC;

  // Registers.
  logic [7:0]  program_erase_control;
  logic [7:0]  nv_module_config;
  logic [7:0]  block_protect_reg;
  logic [1:0]  nv_clock_divider_high;
  logic [7:0]  nv_clock_divider_low;
  logic        lock_high;
  logic        lock_low;
  logic        loaded;
  logic        phase;
  logic        lat_valid;
  eepec_pkg::eepec_state_type state;
  eepec_pkg::eepec_state_type next_state;
  logic [7:0]  next_ctrl;

  // Bus decode: a request is taken, then answered on the next edge.
  wire         req      = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~phase;
  wire         is_arr   = wb_adr_in[`EEPEC_ARR_BIT];
  wire         wr       = phase & wb_we_in & wb_sel_in[0];
  wire         hit_pec  = ~is_arr & (wb_adr_in == `EEPEC_OFS_PEC);
  wire         hit_cfg  = ~is_arr & (wb_adr_in == `EEPEC_OFS_CFG);
  wire         hit_divh = ~is_arr & (wb_adr_in == `EEPEC_OFS_DIVH);
  wire         hit_divl = ~is_arr & (wb_adr_in == `EEPEC_OFS_DIVL);
  wire         hit_prot = ~is_arr & (wb_adr_in == `EEPEC_OFS_PROT);
  wire         hit_stat = ~is_arr & (wb_adr_in == `EEPEC_OFS_STAT);
  wire [11:0]  idx      = wb_adr_in[2 +: `EEPEC_AW];

  // Control bit views.
  wire         pe       = program_erase_control[`EEPEC_PGM];
  wire         latch    = program_erase_control[`EEPEC_LATCH];
  wire         auto_on  = program_erase_control[`EEPEC_AUTO];
  wire         byte_sel = program_erase_control[`EEPEC_BYTE];
  wire         row_sel  = program_erase_control[`EEPEC_ROW];
  wire         erase    = program_erase_control[`EEPEC_ERASE];
  wire         whole_array_erase_guard    = program_erase_control[`EEPEC_WHOLE_ARRAY_ERASE_GUARD];
  wire [9:0]   nv_clock_divider = {nv_clock_divider_high,
                                   nv_clock_divider_low};
  wire         div_zero = (nv_clock_divider == 10'h000);

  // The shadow word answers at its two top-of-block bytes when not hidden.
  wire         shw_vis  = ~nv_module_config[`EEPEC_SHW];
  wire         sh_raddr = shw_vis &
                 (nv_raddr_out[11:1] == SHADOW_LOC[11:1]);
  wire [7:0]   arr_byte = ~sh_raddr ? nv_rdata_in :
                 nv_raddr_out[0] ? shadow_word_in[7:0]
                                 : shadow_word_in[15:8];
  wire [7:0]   stat     = {lat_valid, lock_high, lock_low, 1'b0, state};
  wire [7:0]   rd_byte  = is_arr   ? arr_byte :
                          hit_pec  ? program_erase_control :
                          hit_cfg  ? nv_module_config :
                          hit_divh ? {6'h00, nv_clock_divider_high} :
                          hit_divl ? nv_clock_divider_low :
                          hit_prot ? block_protect_reg :
                          hit_stat ? stat : 8'h00;

  // Erase granularity; the byte bit overrides the row bit.
  wire         is_bulk  = erase & ~byte_sel & ~row_sel;
  wire         is_row   = erase & ~byte_sel & row_sel;

  // Block hit of the latched target, one comparator pair per block.
  logic [5:0]  blk_in;
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_blk
      assign blk_in[g] = (nv_addr_out >= BLK_LO[g]) &&
                         (nv_addr_out <= BLK_HI[g]);
    end
  endgenerate
  wire         blk_hit  = |(blk_in & block_protect_reg[5:0]);
  wire         sh_hit   = shw_vis & block_protect_reg[`EEPEC_SHADOW_PROTECT] &
                 (nv_addr_out[11:1] == SHADOW_LOC[11:1]);
  // A bulk erase touches every block, so any guarded block refuses it.
  wire         refuse   = ((is_bulk | is_row) & whole_array_erase_guard) |
                          (is_bulk & |block_protect_reg[5:0]) |
                          (~is_bulk & (blk_hit | sh_hit | ~lat_valid));
  wire         auto_clr = (state == eepec_pkg::eepec_run) & nv_done_in &
                          auto_on;

  // Array write captures the target only while latching and not enabled.
  wire         arr_wr   = wr & is_arr & latch & ~pe;
  wire         pec_wr   = wr & hit_pec;

  // Next control value; software writes, hardware clears enable.
  always_comb begin
    next_ctrl = program_erase_control;
    if (pec_wr && !pe) begin
      next_ctrl[7:2] = {wb_dat_in[7], 1'b0, wb_dat_in[5:2]};
      if (!div_zero) begin
        next_ctrl[`EEPEC_LATCH] = wb_dat_in[`EEPEC_LATCH];
      end
      // Enable needs the latch already set before this write.
      next_ctrl[`EEPEC_PGM] = wb_dat_in[`EEPEC_PGM] & latch;
    end else if (pec_wr && !wb_dat_in[`EEPEC_PGM]) begin
      next_ctrl[`EEPEC_PGM] = 1'b0;
    end
    if (auto_clr) begin
      next_ctrl[`EEPEC_PGM] = 1'b0;
    end
  end

  // Sequencer; a refused target parks with enable still set.
  always_comb begin
    next_state = state;
    case (state)
      eepec_pkg::eepec_idle: begin
        if (pe) begin
          next_state = refuse ? eepec_pkg::eepec_held
                              : eepec_pkg::eepec_run;
        end
      end
      eepec_pkg::eepec_run: begin
        if (!pe) begin
          next_state = eepec_pkg::eepec_idle;
        end else if (nv_done_in) begin
          next_state = eepec_pkg::eepec_done;
        end
      end
      eepec_pkg::eepec_done,
      eepec_pkg::eepec_held: begin
        if (!pe) begin
          next_state = eepec_pkg::eepec_idle;
        end
      end
      default: next_state = eepec_pkg::eepec_idle;
    endcase
  end

  // Bus handshake and read data.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase        <= 1'b0;
      wb_ack_out   <= 1'b0;
      wb_dat_out   <= 32'h0000_0000;
      nv_raddr_out <= 12'h000;
    end else begin
      phase      <= req;
      wb_ack_out <= phase;
      wb_dat_out <= phase ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      if (req) begin
        nv_raddr_out <= idx;
      end
    end
  end

  // Control register and sequencer state.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      program_erase_control <= `EEPEC_PEC_RST;
      state                 <= eepec_pkg::eepec_idle;
      nv_hv_out             <= 1'b0;
    end else begin
      program_erase_control <= next_ctrl;
      state                 <= next_state;
      // Voltage follows the next run state, gated by the next enable.
      nv_hv_out <= (next_state == eepec_pkg::eepec_run) &
                   next_ctrl[`EEPEC_PGM];
    end
  end

  // Target latches; they cannot move while enabled.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nv_addr_out <= 12'h000;
      nv_data_out <= 16'h0000;
      nv_word_out <= 1'b0;
      lat_valid   <= 1'b0;
    end else if (arr_wr) begin
      nv_addr_out <= idx;
      nv_word_out <= wb_sel_in[1] & ~idx[0];
      nv_data_out <= (wb_sel_in[1] & ~idx[0]) ? wb_dat_in[15:0]
                                              : {8'h00, wb_dat_in[7:0]};
      lat_valid   <= 1'b1;
    end else if (!latch) begin
      lat_valid   <= 1'b0;
    end
  end

  // Configuration, guards and the write-once divider; the shadow word
  // is copied once, on the first edge after reset release.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      loaded                <= 1'b0;
      nv_module_config      <= 8'h00;
      block_protect_reg     <= `EEPEC_PROT_RST;
      nv_clock_divider_high <= 2'h0;
      nv_clock_divider_low  <= 8'h00;
      lock_high             <= 1'b0;
      lock_low              <= 1'b0;
    end else if (!loaded) begin
      loaded                <= 1'b1;
      nv_module_config      <= {shadow_word_in[15:12], 4'h0};
      nv_clock_divider_high <= shadow_word_in[9:8];
      nv_clock_divider_low  <= shadow_word_in[7:0];
    end else begin
      if (wr && hit_cfg) begin
        nv_module_config[7:6] <= wb_dat_in[7:6];
      end
      if (wr && hit_prot) begin
        block_protect_reg <= wb_dat_in[7:0];
      end
      // Normal mode locks each divider byte after its first write.
      if (wr && hit_divh && !(lock_high && special_mode_n_in)) begin
        nv_clock_divider_high <= wb_dat_in[1:0];
        lock_high             <= special_mode_n_in;
      end
      if (wr && hit_divl && !(lock_low && special_mode_n_in)) begin
        nv_clock_divider_low <= wb_dat_in[7:0];
        lock_low             <= special_mode_n_in;
      end
    end
  end

  // Array-facing copies of the mode bits, straight from the register.
  assign nv_latch_out = latch;
  assign nv_erase_out = erase;
  assign nv_byte_out  = byte_sel;
  assign nv_row_out   = row_sel;
  assign nv_div_out   = nv_clock_divider;

  // Checks on the sequencer, the control register and the bus.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  chk_hv_only_pe: assert property (nv_hv_out |-> pe)
    else $error("Program voltage without program enable.");
  chk_bits_held: assert property (pe && $past(pe) |->
      program_erase_control[7:1] == $past(program_erase_control[7:1]))
    else $error("Control bits moved while enabled.");
  chk_pe_latch: assert property ($rose(pe) |-> $past(latch))
    else $error("Program enable set without prior latch.");
  chk_latch_div: assert property ($rose(latch) |-> $past(!div_zero && !pe))
    else $error("Latch set with zero divider or enable.");
  chk_auto_clr: assert property (auto_clr |=> !pe ##1
      state == eepec_pkg::eepec_idle)
    else $error("Auto clear did not end the cycle.");
  chk_refused_hold: assert property (state == eepec_pkg::eepec_held
      && pe |-> !nv_hv_out)
    else $error("Refused target drove the voltage.");
  chk_latch_fixed: assert property (pe && $past(pe) |->
      $stable(nv_addr_out) && $stable(nv_data_out))
    else $error("Latched target changed while enabled.");
  chk_div_lock: assert property (special_mode_n_in && $past(lock_low)
      |-> $stable(nv_clock_divider_low))
    else $error("Locked divider changed in normal mode.");
  chk_bus_answer: assert property (req |=> phase ##1 wb_ack_out ##1
      !wb_ack_out)
    else $error("Bus answer not two cycles after request.");

  cov_run_done: cover property (state == eepec_pkg::eepec_run ##1
      state == eepec_pkg::eepec_done);
  cov_refused: cover property (state == eepec_pkg::eepec_held);
  cov_word_latch: cover property (arr_wr && wb_sel_in[1]);

endmodule // eepec_top
